// File: hdl/gpes_pkg.sv
// Package with the register map, field layout and codes of the pin event block.
package gpes_pkg;
    localparam int PIN_COUNT = 4;
    localparam logic [7:0] ADDR_IRQ_MASK = 8'h05;
    localparam logic [7:0] ADDR_EDGE_SELECT = 8'h07;
    localparam logic [7:0] ADDR_IRQ_CAUSE = 8'h08;
    localparam logic [7:0] ADDR_EVENT_FLAGS = 8'h09;
    localparam logic [7:0] ADDR_LOGIC_MODE = 8'h10;
    localparam logic [7:0] ADDR_TABLE_TWO_IN = 8'h11;
    localparam logic [7:0] ADDR_TABLE_UNUSED_A = 8'h12;
    localparam logic [7:0] ADDR_TABLE_THREE_IN = 8'h13;
    localparam logic [7:0] ADDR_TABLE_UNUSED_B = 8'h14;
    localparam logic [7:0] ADDR_TABLE_UNUSED_C = 8'h15;
    localparam logic [7:0] ADDR_ADVANCED = 8'hAB;
    localparam logic [3:0] RST_IRQ_MASK = 4'hF;
    localparam logic [3:0] IRQ_MASK_UPPER = 4'hF;
    localparam logic [7:0] RST_EDGE_SELECT = 8'h00;
    localparam logic [3:0] RST_FLAGS = 4'h0;
    localparam logic [3:0] RST_TABLE_TWO_IN = 4'h0;
    localparam logic [7:0] RST_TABLE_THREE_IN = 8'h00;
    localparam logic RST_BOOST = 1'b0;
    localparam int BOOST_BIT = 1;
    localparam int MODE_LSB = 0;
    localparam int TWO_IN_OUT_PIN = 2;
    localparam int THREE_IN_OUT_PIN = 3;
    localparam logic [7:0] READ_ZERO = 8'h00;
    localparam logic [1:0] SENSE_NONE = 2'h0;
    localparam logic [1:0] SENSE_RISING = 2'h1;
    localparam logic [1:0] SENSE_FALLING = 2'h2;
    localparam logic [1:0] SENSE_BOTH = 2'h3;
    typedef enum logic [1:0]
    {
        MODE_GPIO = 2'h0,
        MODE_TWO_IN = 2'h1,
        MODE_THREE_IN = 2'h2,
        MODE_UNUSED = 2'h3
    } gpes_mode_type;
endpackage

// File: hdl/gpes_pin_sync.sv
// Pin input synchroniser with agreement filter and edge classification.
`timescale 1ns/100ps
`default_nettype none
module gpes_pin_sync #(
    parameter int WIDTH = 4
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic [WIDTH-1:0] pin_in,
    input wire logic [2*WIDTH-1:0] edge_select,
    output logic [WIDTH-1:0] level,
    output logic [WIDTH-1:0] edge_hit
);
    logic [WIDTH-1:0] stage_a;
    logic [WIDTH-1:0] stage_b;
    logic [WIDTH-1:0] stage_c;
    logic primed;
    logic [2:0] filled;

    if (WIDTH < 1)
    begin : g_bad_width
        $error("gpes_pin_sync needs at least one pin");
    end

    // The first agreed level after reset is loaded without an event, so a
    // pin that idles high does not report a false rising edge. Priming waits
    // until the third stage holds a real sample rather than its reset zero.
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            filled <= 3'h0;
            primed <= 1'b0;
        end
        else
        begin
            filled <= {filled[1:0], 1'b1};
            primed <= primed | (filled[2] & (stage_b == stage_c));
        end
    end

    genvar i;
    generate
        for (i = 0; i < WIDTH; i++)
        begin : g_pin
            wire agree = (stage_b[i] == stage_c[i]);
            wire changed = primed & agree & (stage_c[i] != level[i]);
            wire [1:0] sense = edge_select[2*i+1:2*i];
            wire rise_ok = (sense == gpes_pkg::SENSE_RISING) |
                (sense == gpes_pkg::SENSE_BOTH);
            wire fall_ok = (sense == gpes_pkg::SENSE_FALLING) |
                (sense == gpes_pkg::SENSE_BOTH);
            wire next_hit = changed & (stage_c[i] ? rise_ok : fall_ok);
            wire next_level = agree ? stage_c[i] : level[i];

            always_ff @(posedge ref_clk or posedge rst)
            begin
                if (rst)
                begin
                    stage_a[i] <= 1'b0;
                    stage_b[i] <= 1'b0;
                    stage_c[i] <= 1'b0;
                    level[i] <= 1'b0;
                    edge_hit[i] <= 1'b0;
                end
                else
                begin
                    stage_a[i] <= pin_in[i];
                    stage_b[i] <= stage_a[i];
                    stage_c[i] <= stage_b[i];
                    level[i] <= next_level;
                    edge_hit[i] <= next_hit;
                end
            end

            a_hit_sense_kind: assert property (
                @(posedge ref_clk) disable iff (rst)
                edge_hit[i] |-> ($past(sense) != gpes_pkg::SENSE_NONE))
                else $error("edge reported with sense set to none");
        end
    endgenerate
endmodule
`default_nettype wire

// File: hdl/gpes_logic_decode.sv
// Truth-table decode that takes over pin 2 or pin 3 in logic modes.
`timescale 1ns/100ps
`default_nettype none
module gpes_logic_decode (
    input wire gpes_pkg::gpes_mode_type mode,
    input wire logic [3:0] table_two_in,
    input wire logic [7:0] table_three_in,
    input wire logic [3:0] pin_level,
    input wire logic [3:0] data_value,
    input wire logic [3:0] dir_input,
    output logic [3:0] pin_value,
    output logic [3:0] pin_drive
);
    // Only pins 1 and 0 feed the two-input table, pins 2 to 0 the other.
    wire two_in_bit = table_two_in[pin_level[1:0]];
    wire three_in_bit = table_three_in[pin_level[2:0]];
    wire two_in_on = (mode == gpes_pkg::MODE_TWO_IN);
    wire three_in_on = (mode == gpes_pkg::MODE_THREE_IN);
    wire [3:0] take_two = 4'h1 << gpes_pkg::TWO_IN_OUT_PIN;
    wire [3:0] take_three = 4'h1 << gpes_pkg::THREE_IN_OUT_PIN;
    wire [3:0] taken = (two_in_on ? take_two : 4'h0) |
        (three_in_on ? take_three : 4'h0);
    wire [3:0] decoded = (two_in_on ? {4{two_in_bit}} & take_two : 4'h0) |
        (three_in_on ? {4{three_in_bit}} & take_three : 4'h0);

    // A decoded pin is forced to drive; the unused mode code falls back
    // to plain I/O rather than guessing at a meaning.
    assign pin_value = (data_value & ~taken) | decoded;
    assign pin_drive = ~dir_input | taken;
endmodule
`default_nettype wire

// File: hdl/gpes_top.sv
// Pin event flags, interrupt causes and logic decode of a four-pin expander.
//
// Overview of operation
// - Each pin's event flag is set by an edge of the kind its sense selects.
// - Writing one to an event bit clears it and its interrupt cause bit.
// - Changing a pin's edge sense clears its event and cause flags.
// - Logic mode 00 leaves all pins as plain I/O and 11 is not relied upon.
// - Logic mode 01 drives pin 2 from the two-input table via pins 1 and 0.
// - Logic mode 10 drives pin 3 from the three-input table via pins 2 to 0.
// - Two-input table bits 3 to 0 serve patterns 11 to 00; bits 7:4 reserved.
// - The two-input table acts only in two-input decode mode.
// - Three-input table bits 7 to 0 serve patterns 111 to 000, in mode 10.
// - Advanced bit 1 turns output boost off or on and resets to zero.
// - The active-low interrupt output goes high once all causes are clear.
// - A two-bit sense field selects none, rising, falling or both edges.
`timescale 1ns/100ps
`default_nettype none
module gpes_top #(
    parameter int PIN_COUNT = gpes_pkg::PIN_COUNT
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    input wire logic [3:0] io_in,
    input wire logic [3:0] io_data_reg,
    input wire logic [3:0] io_dir,
    output logic [3:0] io_out,
    output logic [3:0] io_oe_n,
    output logic irq_out_low,
    output logic boost_on
);
    logic [3:0] irq_mask;
    logic [7:0] edge_select;
    logic [3:0] io_event_flags;
    logic [3:0] irq_cause_flags;
    gpes_pkg::gpes_mode_type logic_mode_select;
    logic [3:0] truth_table_two_in;
    logic [7:0] truth_table_three_in;
    logic [3:0] pin_level;
    logic [3:0] edge_hit;
    logic [3:0] pin_value;
    logic [3:0] pin_drive;
    logic [3:0] sense_changed;

    generate
        if (PIN_COUNT != 4)
        begin : g_bad_count
            $error("gpes_top serves exactly four pins");
        end
    endgenerate

    gpes_pin_sync #(
        .WIDTH(4)
    ) u_sync (
        .ref_clk(ref_clk),
        .rst(rst),
        .pin_in(io_in),
        .edge_select(edge_select),
        .level(pin_level),
        .edge_hit(edge_hit)
    );

    gpes_logic_decode u_decode (
        .mode(logic_mode_select),
        .table_two_in(truth_table_two_in),
        .table_three_in(truth_table_three_in),
        .pin_level(pin_level),
        .data_value(io_data_reg),
        .dir_input(io_dir),
        .pin_value(pin_value),
        .pin_drive(pin_drive)
    );

    // Each write is a one-cycle strobe qualified by its address.
    wire wr_mask = reg_wr & (reg_addr == gpes_pkg::ADDR_IRQ_MASK);
    wire wr_sense = reg_wr & (reg_addr == gpes_pkg::ADDR_EDGE_SELECT);
    wire wr_cause = reg_wr & (reg_addr == gpes_pkg::ADDR_IRQ_CAUSE);
    wire wr_event = reg_wr & (reg_addr == gpes_pkg::ADDR_EVENT_FLAGS);
    wire wr_mode = reg_wr & (reg_addr == gpes_pkg::ADDR_LOGIC_MODE);
    wire wr_two = reg_wr & (reg_addr == gpes_pkg::ADDR_TABLE_TWO_IN);
    wire wr_three = reg_wr & (reg_addr == gpes_pkg::ADDR_TABLE_THREE_IN);
    wire wr_adv = reg_wr & (reg_addr == gpes_pkg::ADDR_ADVANCED);

    genvar i;
    generate
        for (i = 0; i < 4; i++)
        begin : g_sense
            assign sense_changed[i] = wr_sense &
                (reg_wdata[2*i+1:2*i] != edge_select[2*i+1:2*i]);
        end
    endgenerate

    // Either flag register clears both, as one write-one is one acknowledge.
    wire [3:0] w1c = (wr_event | wr_cause) ? reg_wdata[3:0] : 4'h0;
    wire [3:0] clear_any = w1c | sense_changed;
    // A new edge in the clearing cycle wins so no event is lost.
    wire [3:0] next_event = (io_event_flags & ~clear_any) | edge_hit;
    wire [3:0] next_cause = (irq_cause_flags & ~clear_any) |
        (edge_hit & ~irq_mask);
    wire next_irq_low = ~|next_cause;
    // The mode is stored as written; code 11 reads back but decodes as
    // plain I/O, so software that sets it by mistake takes no pin over.
    wire gpes_pkg::gpes_mode_type next_mode =
        gpes_pkg::gpes_mode_type'(reg_wdata[gpes_pkg::MODE_LSB+:2]);

    // Unused table addresses fall through to a zero read.
    wire [7:0] next_rdata =
        (reg_addr == gpes_pkg::ADDR_IRQ_MASK) ?
            {gpes_pkg::IRQ_MASK_UPPER, irq_mask} :
        (reg_addr == gpes_pkg::ADDR_EDGE_SELECT) ? edge_select :
        (reg_addr == gpes_pkg::ADDR_IRQ_CAUSE) ? {4'h0, irq_cause_flags} :
        (reg_addr == gpes_pkg::ADDR_EVENT_FLAGS) ? {4'h0, io_event_flags} :
        (reg_addr == gpes_pkg::ADDR_LOGIC_MODE) ? {6'h00, logic_mode_select} :
        (reg_addr == gpes_pkg::ADDR_TABLE_TWO_IN) ?
            {4'h0, truth_table_two_in} :
        (reg_addr == gpes_pkg::ADDR_TABLE_THREE_IN) ? truth_table_three_in :
        (reg_addr == gpes_pkg::ADDR_ADVANCED) ? {6'h00, boost_on, 1'b0} :
        gpes_pkg::READ_ZERO;

    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            io_event_flags <= gpes_pkg::RST_FLAGS;
            irq_cause_flags <= gpes_pkg::RST_FLAGS;
            irq_out_low <= 1'b1;
            reg_rdata <= gpes_pkg::READ_ZERO;
        end
        else
        begin
            io_event_flags <= next_event;
            irq_cause_flags <= next_cause;
            irq_out_low <= next_irq_low;
            reg_rdata <= reg_rd ? next_rdata : reg_rdata;
        end
    end

    // Reserved bits are not stored, so a careless write does no harm.
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            irq_mask <= gpes_pkg::RST_IRQ_MASK;
            edge_select <= gpes_pkg::RST_EDGE_SELECT;
            logic_mode_select <= gpes_pkg::MODE_GPIO;
            truth_table_two_in <= gpes_pkg::RST_TABLE_TWO_IN;
            truth_table_three_in <= gpes_pkg::RST_TABLE_THREE_IN;
            boost_on <= gpes_pkg::RST_BOOST;
        end
        else
        begin
            irq_mask <= wr_mask ? reg_wdata[3:0] : irq_mask;
            edge_select <= wr_sense ? reg_wdata : edge_select;
            logic_mode_select <= wr_mode ? next_mode : logic_mode_select;
            truth_table_two_in <= wr_two ? reg_wdata[3:0] :
                truth_table_two_in;
            truth_table_three_in <= wr_three ? reg_wdata :
                truth_table_three_in;
            boost_on <= wr_adv ? reg_wdata[gpes_pkg::BOOST_BIT] :
                boost_on;
        end
    end

    // Pin drivers are registered, so a decoded output lags its inputs.
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            io_out <= 4'h0;
            io_oe_n <= 4'hF;
        end
        else
        begin
            io_out <= pin_value;
            io_oe_n <= ~pin_drive;
        end
    end

    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (rst);

    // The sequences name the steps of a flag's life: the write that clears
    // it, the edge that sets it and the interrupt that it raises.
    sequence s_event_write(int b);
        wr_event && reg_wdata[b] && !edge_hit[b];
    endsequence

    sequence s_cause_write(int b);
        wr_cause && reg_wdata[b] && !edge_hit[b];
    endsequence

    sequence s_flags_cleared(int b);
        !io_event_flags[b] && !irq_cause_flags[b];
    endsequence

    sequence s_unmasked_edge(int b);
        edge_hit[b] && !irq_mask[b];
    endsequence

    sequence s_cause_raised(int b);
        irq_cause_flags[b] && !irq_out_low;
    endsequence

    generate
        for (i = 0; i < 4; i++)
        begin : g_check
            a_event_on_edge: assert property (
                edge_hit[i] |=> io_event_flags[i])
                else $error("edge did not set its event flag");
            a_no_spurious_event: assert property (
                !edge_hit[i] && !io_event_flags[i] |=> !io_event_flags[i])
                else $error("event flag rose without an edge");
            a_event_w1c_clears: assert property (
                s_event_write(i) |=> s_flags_cleared(i))
                else $error("write of one left event or cause set");
            a_cause_w1c_clears: assert property (
                s_cause_write(i) |=> s_flags_cleared(i))
                else $error("cause write of one left a flag set");
            a_event_w0_keeps: assert property (
                wr_event && !reg_wdata[i] && !wr_sense &&
                io_event_flags[i] |=> io_event_flags[i])
                else $error("write of zero cleared an event");
            a_sense_change_clears: assert property (
                sense_changed[i] && !edge_hit[i] |=> s_flags_cleared(i))
                else $error("sense change left flags set");
            a_sense_same_keeps: assert property (
                wr_sense && !sense_changed[i] && io_event_flags[i] |=>
                io_event_flags[i])
                else $error("unchanged sense field cleared an event");
            a_cause_on_edge: assert property (
                s_unmasked_edge(i) |=> s_cause_raised(i))
                else $error("unmasked edge raised no interrupt");
            a_mask_no_cause: assert property (
                edge_hit[i] && irq_mask[i] && !irq_cause_flags[i] |=>
                !irq_cause_flags[i])
                else $error("masked edge raised a cause");
            a_cause_has_event: assert property (
                irq_cause_flags[i] |-> io_event_flags[i])
                else $error("cause flag stands without its event");
        end
    endgenerate

    // Pin outputs are registered, so each output check looks one edge
    // after the mode and the inputs that produced it.
    a_gpio_mode_data: assert property (
        logic_mode_select == gpes_pkg::MODE_GPIO |=>
        io_out == $past(io_data_reg) && io_oe_n == $past(io_dir))
        else $error("plain mode output differs from data");
    a_mode_unused_plain: assert property (
        logic_mode_select == gpes_pkg::MODE_UNUSED |=>
        io_out == $past(io_data_reg) && io_oe_n == $past(io_dir))
        else $error("unused mode code did not act as plain mode");
    a_two_in_decode: assert property (
        logic_mode_select == gpes_pkg::MODE_TWO_IN |=>
        io_out[2] == $past(truth_table_two_in[pin_level[1:0]]) &&
        !io_oe_n[2] && io_out[3] == $past(io_data_reg[3]))
        else $error("pin 2 decode mismatch");
    a_three_in_decode: assert property (
        logic_mode_select == gpes_pkg::MODE_THREE_IN |=>
        io_out[3] == $past(truth_table_three_in[pin_level[2:0]]) &&
        !io_oe_n[3] && io_out[2] == $past(io_data_reg[2]))
        else $error("pin 3 decode mismatch");
    a_three_low_patterns: assert property (
        logic_mode_select == gpes_pkg::MODE_THREE_IN && !pin_level[2] |=>
        io_out[3] == $past(truth_table_three_in[{1'b0, pin_level[1:0]}]))
        else $error("low three-input pattern took the wrong bit");
    a_two_table_ignored: assert property (
        logic_mode_select != gpes_pkg::MODE_TWO_IN |=>
        io_out[2] == $past(io_data_reg[2]))
        else $error("two-input table reached pin 2 outside its mode");
    a_three_table_ignored: assert property (
        logic_mode_select != gpes_pkg::MODE_THREE_IN |=>
        io_out[3] == $past(io_data_reg[3]))
        else $error("three-input table reached pin 3 outside its mode");
    a_inputs_kept: assert property (
        logic_mode_select != gpes_pkg::MODE_GPIO |=>
        io_oe_n[1:0] == $past(io_dir[1:0]))
        else $error("decode mode changed the direction of pins 1 and 0");
    a_reserved_two_in: assert property (
        reg_rd && reg_addr == gpes_pkg::ADDR_TABLE_TWO_IN |=>
        reg_rdata[7:4] == 4'h0)
        else $error("reserved two-input table bits read as set");
    a_boost_follows_write: assert property (
        wr_adv |=> boost_on == $past(reg_wdata[gpes_pkg::BOOST_BIT]))
        else $error("boost did not take written bit");
    a_boost_holds: assert property (
        !wr_adv |=> $stable(boost_on))
        else $error("boost changed without a write");
    a_irq_release: assert property (
        irq_cause_flags == 4'h0 && (edge_hit & ~irq_mask) == 4'h0 |=>
        irq_out_low)
        else $error("interrupt held low with no cause");
    a_irq_asserts: assert property (
        irq_out_low == (irq_cause_flags == 4'h0))
        else $error("interrupt level disagrees with the causes");
endmodule
`default_nettype wire

// File: verif/gpes_host_model.sv
// Host model that reaches the device registers over the register port.
`timescale 1ns/100ps
`default_nettype none
module gpes_host_model (
    input wire logic ref_clk,
    output logic [7:0] reg_addr,
    output logic [7:0] reg_wdata,
    output logic reg_wr,
    output logic reg_rd,
    input wire logic [7:0] reg_rdata
);
    initial
    begin
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
    end
    // Reserved mode bits 7 to 2 and advanced bit 0 always go out as zero.
    task automatic write(input logic [7:0] a, input logic [7:0] d);
        logic [7:0] v;
        v = d;
        if (a == gpes_pkg::ADDR_LOGIC_MODE) v = d & 8'h03;
        if (a == gpes_pkg::ADDR_ADVANCED) v = d & 8'hFE;
        @(posedge ref_clk);
        #1;
        reg_addr = a;
        reg_wdata = v;
        reg_wr = 1'b1;
        @(posedge ref_clk);
        #1;
        reg_wr = 1'b0;
        // Lines are inverted after the access so stale values never help.
        reg_addr = ~a;
        reg_wdata = ~v;
    endtask
    task automatic read(input logic [7:0] a, output logic [7:0] d);
        @(posedge ref_clk);
        #1;
        reg_addr = a;
        reg_rd = 1'b1;
        @(posedge ref_clk);
        #1;
        d = reg_rdata;
        reg_rd = 1'b0;
        reg_addr = ~a;
    endtask
endmodule
`default_nettype wire

// File: verif/gpio_event_status_and_pld_bench.sv
// Self-checking bench for the pin event flags and logic decode.
`timescale 1ns/100ps
`default_nettype none
module gpio_event_status_and_pld_bench;
    logic ref_clk;
    logic rst;
    logic [7:0] reg_addr;
    logic [7:0] reg_wdata;
    logic reg_wr;
    logic reg_rd;
    logic [7:0] reg_rdata;
    logic [3:0] io_in;
    logic [3:0] io_data_reg;
    logic [3:0] io_dir;
    logic [3:0] io_out;
    logic [3:0] io_oe_n;
    logic irq_out_low;
    logic boost_on;
    int n_errors = 0;
    int checks = 0;
    gpes_top dut_u (.ref_clk(ref_clk), .rst(rst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .io_in(io_in), .io_data_reg(io_data_reg),
        .io_dir(io_dir), .io_out(io_out), .io_oe_n(io_oe_n),
        .irq_out_low(irq_out_low), .boost_on(boost_on));
    gpes_host_model host_u (.ref_clk(ref_clk), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata));
    initial
    begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end
    task automatic check(input string name, input logic [7:0] seen,
        input logic [7:0] exp);
        checks++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("BAD %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic complete_run;
        $display("checks %0d errors %0d", checks, n_errors);
        if (n_errors == 0 && checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    // Pin levels pass a three-flop filter, so eight cycles cover it.
    task automatic set_pins(input logic [3:0] v);
        @(posedge ref_clk);
        #1;
        io_in = v;
        repeat (8) @(posedge ref_clk);
        #1;
    endtask
    function automatic logic [7:0] exp_pins(logic [1:0] m, logic [7:0] t2,
        logic [7:0] t3, logic [3:0] lv, logic [3:0] dir, logic [3:0] dat);
        logic [3:0] oe_n;
        logic [3:0] o;
        oe_n = dir;
        o = dat & ~dir;
        if (m == 2'h1)
        begin
            oe_n[2] = 1'b0;
            o[2] = t2[lv[1:0]];
        end
        if (m == 2'h2)
        begin
            oe_n[3] = 1'b0;
            o[3] = t3[lv[2:0]];
        end
        return {oe_n, o};
    endfunction
    initial
    begin
        repeat (20000) @(posedge ref_clk);
        n_errors++;
        complete_run();
    end
    initial
    begin
        logic [7:0] d;
        logic [7:0] t2;
        logic [7:0] t3;
        logic [7:0] e;
        logic [1:0] m;
        logic [7:0] raddr [7];
        raddr = '{8'h10, 8'h11, 8'h12, 8'h13, 8'h14, 8'h15, 8'hAB};
        rst = 1'b1;
        io_in = 4'h0;
        io_data_reg = 4'h0;
        io_dir = 4'hF;
        void'($urandom(32'h9947c792));
        repeat (12) @(posedge ref_clk);
        #1;
        rst = 1'b0;
        check("boost_rst", {7'h0, boost_on}, 8'h00);
        foreach (raddr[i])
        begin
            host_u.read(raddr[i], d);
            check("reg_rst", d, 8'h00);
        end
        host_u.write(gpes_pkg::ADDR_IRQ_MASK, 8'hFE);
        for (int s = 0; s < 4; s++)
        begin
            host_u.write(gpes_pkg::ADDR_EDGE_SELECT, s[7:0]);
            set_pins(4'h1);
            host_u.read(gpes_pkg::ADDR_EVENT_FLAGS, d);
            check("rise_flag", d, {7'h0, s[0]});
            host_u.read(gpes_pkg::ADDR_IRQ_CAUSE, d);
            check("rise_cause", d, {7'h0, s[0]});
            check("irq_low", {7'h0, irq_out_low}, {7'h0, ~s[0]});
            host_u.write(gpes_pkg::ADDR_EVENT_FLAGS, 8'h00);
            host_u.read(gpes_pkg::ADDR_EVENT_FLAGS, d);
            check("w0_keeps", d, {7'h0, s[0]});
            host_u.write(gpes_pkg::ADDR_EVENT_FLAGS, 8'h01);
            host_u.read(gpes_pkg::ADDR_EVENT_FLAGS, d);
            check("w1_clear", d, 8'h00);
            check("irq_high", {7'h0, irq_out_low}, 8'h01);
            set_pins(4'h0);
            host_u.read(gpes_pkg::ADDR_EVENT_FLAGS, d);
            check("fall_flag", d, {7'h0, s[1]});
            if (s == 3)
                host_u.write(gpes_pkg::ADDR_EDGE_SELECT, 8'h01);
            else
                host_u.write(gpes_pkg::ADDR_IRQ_CAUSE, 8'h01);
            host_u.read(gpes_pkg::ADDR_EVENT_FLAGS, d);
            check("flag_clear", d, 8'h00);
            check("irq_clear", {7'h0, irq_out_low}, 8'h01);
        end
        host_u.write(gpes_pkg::ADDR_EDGE_SELECT, 8'h00);
        for (int i = 0; i < 24; i++)
        begin
            m = 2'(i % 4);
            t2 = 8'($urandom);
            t3 = 8'($urandom);
            host_u.write(gpes_pkg::ADDR_LOGIC_MODE, {6'h0, m});
            host_u.write(gpes_pkg::ADDR_TABLE_TWO_IN, t2);
            host_u.write(gpes_pkg::ADDR_TABLE_THREE_IN, t3);
            host_u.read(gpes_pkg::ADDR_TABLE_TWO_IN, d);
            check("table_two", d, t2 & 8'h0F);
            @(posedge ref_clk);
            #1;
            io_dir = 4'($urandom);
            io_data_reg = 4'($urandom);
            set_pins(4'($urandom));
            e = exp_pins(m, t2, t3, io_in, io_dir, io_data_reg);
            check("pins", {io_oe_n, io_out & ~e[7:4]}, e);
        end
        host_u.write(gpes_pkg::ADDR_ADVANCED, 8'h03);
        check("boost_on", {7'h0, boost_on}, 8'h01);
        host_u.read(gpes_pkg::ADDR_ADVANCED, d);
        check("advanced", d, 8'h02);
        host_u.write(gpes_pkg::ADDR_ADVANCED, 8'h00);
        check("boost_off", {7'h0, boost_on}, 8'h00);
        host_u.write(gpes_pkg::ADDR_LOGIC_MODE, 8'h02);
        rst = 1'b1;
        repeat (3) @(posedge ref_clk);
        #1;
        rst = 1'b0;
        check("oe_rst", {4'h0, io_oe_n}, 8'h0F);
        check("irq_rst", {7'h0, irq_out_low}, 8'h01);
        host_u.read(gpes_pkg::ADDR_LOGIC_MODE, d);
        check("mode_rst", d, 8'h00);
        complete_run();
    end
endmodule
`default_nettype wire
